// file: logic/swcc_pkg.sv
package swcc_pkg;
  // =====================================================
  // Register offsets (byte addresses: index times four)
  localparam logic [3:0] IDX_WIDE_CHAIN = 4'h2;
  localparam logic [3:0] IDX_CLK_DIV    = 4'h3;
  localparam logic [3:0] IDX_OWN_ID     = 4'h4;
  localparam logic [3:0] IDX_PARITY     = 4'h5;
  localparam logic [3:0] IDX_RESIDUE    = 4'h6;
  localparam logic [3:0] IDX_ODL        = 4'h7;
  localparam logic [3:0] IDX_IRQ_STAT0  = 4'h8;
  // =====================================================
  // Field positions, wide_chain_control
  localparam int BIT_GUARD    = 7;
  localparam int BIT_CHAIN    = 6;
  localparam int BIT_PWMODE   = 5;
  localparam int BIT_PHIGH    = 4;
  localparam int BIT_WSEND    = 3;
  localparam int BIT_GCKIND   = 2;
  localparam int BIT_RLDDIS   = 1;
  localparam int BIT_WRECV    = 0;
  // clock_divider_control / own_bus_id / interrupt status
  localparam int BIT_WIDE_EN  = 3;
  localparam int BIT_UDC      = 2;
  localparam logic [7:0] MASK_CLK_DIV = 8'h7f;
  localparam logic [7:0] MASK_OWN_ID  = 8'h6f;
  localparam logic [7:0] RESET_BYTE   = 8'h00;
  // =====================================================
  // Divider codes
  localparam logic [2:0] DIV3A  = 3'h0;
  localparam logic [2:0] DIV1   = 3'h1;
  localparam logic [2:0] DIV1P5 = 3'h2;
  localparam logic [2:0] DIV2   = 3'h3;
  localparam logic [2:0] DIV3B  = 3'h4;
  // Standard group codes are 0,1,2,5 (top three bits of opcode)
  localparam logic [7:0] STD_GROUPS = 8'h27;
endpackage : swcc_pkg

// file: logic/swcc_wide_chain_clock_ctrl.sv
`timescale 1ns/1ps
// Overview of operation
// R1 - Initiator, guard set, bus free: raise unexpected disconnect in status bit 2.
// R2 - Guard sets itself on reselection or successful selection.
// R3 - Software clears guard with a zero write before expected disconnects.
// R4 - Chained move sets chained mode; ordinary block move clears it.
// R5 - Chained odd-byte end holds last byte, paired with next first byte.
// R6 - Parity word mode shows selected parity byte and accepts a written seed.
// R7 - High-byte select: clear shows low byte, set shows high byte.
// R8 - Wide send bit reads flag; writing one clears it, self-resetting.
// R9 - Held send byte goes out as low byte of next send.
// R10 - Receive or non-wide transfer clears wide send flag.
// R11 - Group-code kind is read-only, resets zero, reloads each async target receive.
// R12 - Command-phase reload on standard group code unless reload disabled.
// R13 - Wide receive bit reads flag; writing one clears it, self-resetting.
// R14 - Partial wide receive holds high byte in residue, sets receive flag.
// R15 - Send or non-wide transfer clears receive flag; held byte delivered next receive.
// R16 - Sync divider in bits 6-4 divides the source clock for sync logic.
// R17 - Wide enable: data phases 16-bit, other phases always 8-bit.
// R18 - Clearing wide enable clears the wide receive flag.
// R19 - Divider codes 0:/3, 1:/1, 2:/1.5, 3:/2, 4:/3; 5-7 reserved.
// R20 - Software picks divider code to match source clock range.
// R21 - Own-ID low four bits hold the arbitration ID.
// R22 - Reserved bits ignore writes and read back harmlessly.
module swcc_wide_chain_clock_ctrl (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [31:0] wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output logic             wb_ack_o,
  output logic             wb_err_o,
  input  wire logic        initiatorMode,
  input  wire logic        busFree,
  input  wire logic        scriptActive,
  input  wire logic        reselected,
  input  wire logic        selectDone,
  input  wire logic        chainedMoveOp,
  input  wire logic        blockMoveOp,
  input  wire logic        xferStart,
  input  wire logic        xferSend,
  input  wire logic        dataPhase,
  input  wire logic        cmdPhase,
  input  wire logic        asyncTarget,
  input  wire logic        byteValid,
  input  wire logic [15:0] byteIn,
  input  wire logic        lastBeat,
  input  wire logic        oddEnd,
  input  wire logic [15:0] sendWordIn,
  input  wire logic [15:0] parityWordIn,
  output logic             byteCountReload,
  output logic             unexpectedDisconnect,
  output logic [15:0]      busDataOut,
  output logic [15:0]      dmaDataOut,
  output logic             dmaValid,
  output logic             wideXfer,
  output logic [3:0]       arbId,
  output logic             coreClkEn,
  output logic             syncClkEn
);
  // =====================================================
  // Bus slave
  logic [3:0] idx;
  logic       hit, wrEn, mapped;
  logic [7:0] wdat;
  assign idx    = wb_adr_i[5:2];
  assign hit    = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  assign mapped = (wb_adr_i[31:6] == 26'h0) && (wb_adr_i[1:0] == 2'h0)
                  && (idx >= swcc_pkg::IDX_WIDE_CHAIN) && (idx <= swcc_pkg::IDX_IRQ_STAT0);
  assign wrEn   = hit && mapped && wb_we_i && wb_sel_i[0];
  assign wdat   = wb_dat_i[7:0];

  function automatic logic wr(input logic [3:0] i);
    wr = wrEn && (idx == i);
  endfunction : wr
  // Divider code to half-cycle numerator (div by n/2 via count of halves)
  function automatic logic [2:0] halfSteps(input logic [2:0] code);
    unique case (code)
      swcc_pkg::DIV1:   halfSteps = 3'h2;
      swcc_pkg::DIV1P5: halfSteps = 3'h3;
      swcc_pkg::DIV2:   halfSteps = 3'h4;
      default:          halfSteps = 3'h6;
    endcase
  endfunction : halfSteps
  // One step of the half-cycle accumulator: {enable pulse, next value}
  function automatic logic [4:0] accStep(input logic [3:0] acc, input logic [2:0] step);
    logic [3:0] sum;
    sum = acc + 4'h2;
    accStep = (sum >= {1'b0, step}) ? {1'b1, sum - {1'b0, step}} : {1'b0, sum};
  endfunction : accStep
  // =====================================================
  // Registers
  logic        guard_reg, chain_reg, pwMode_reg, pHigh_reg;
  logic        wSend_reg, gcKind_reg, rldDis_reg, wRecv_reg;
  logic        seedValid_reg, udc_reg, firstByte_reg, wideEn;
  logic [6:0]  clkDiv_reg;
  logic [7:0]  ownId_reg, residue_reg, odl_reg;
  logic [15:0] parSeed_reg;
  assign wideEn = clkDiv_reg[swcc_pkg::BIT_WIDE_EN];
  assign wideXfer = wideEn && dataPhase; // R17
  assign arbId = ownId_reg[3:0]; // R21

  always_ff @(posedge clk)
  begin
    if (rst)
      guard_reg <= 1'b0;
    else if (scriptActive && (reselected || selectDone))
      guard_reg <= 1'b1; // R2
    else if (wr(swcc_pkg::IDX_WIDE_CHAIN))
      guard_reg <= wdat[swcc_pkg::BIT_GUARD]; // R3
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      udc_reg <= 1'b0;
    else if (initiatorMode && guard_reg && busFree)
      udc_reg <= 1'b1; // R1
    else if (wr(swcc_pkg::IDX_IRQ_STAT0) && wdat[swcc_pkg::BIT_UDC])
      udc_reg <= 1'b0;
  end
  assign unexpectedDisconnect = udc_reg;
  always_ff @(posedge clk)
  begin
    if (rst)
      chain_reg <= 1'b0;
    else if (chainedMoveOp)
      chain_reg <= 1'b1; // R4
    else if (blockMoveOp)
      chain_reg <= 1'b0; // R4
    else if (wr(swcc_pkg::IDX_WIDE_CHAIN))
      chain_reg <= wdat[swcc_pkg::BIT_CHAIN];
  end
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      pwMode_reg <= 1'b0;
      pHigh_reg  <= 1'b0;
      rldDis_reg <= 1'b0;
    end
    else if (wr(swcc_pkg::IDX_WIDE_CHAIN))
    begin
      pwMode_reg <= wdat[swcc_pkg::BIT_PWMODE];
      pHigh_reg  <= wdat[swcc_pkg::BIT_PHIGH];
      rldDis_reg <= wdat[swcc_pkg::BIT_RLDDIS];
    end
  end
  // Seed written through the parity register in word mode only
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      parSeed_reg   <= 16'h0000;
      seedValid_reg <= 1'b0;
    end
    else if (wr(swcc_pkg::IDX_PARITY) && pwMode_reg)
    begin
      seedValid_reg <= 1'b1; // R6
      if (pHigh_reg)
        parSeed_reg[15:8] <= wdat;
      else
        parSeed_reg[7:0] <= wdat;
    end
    else if (xferStart)
      seedValid_reg <= 1'b0;
  end
  logic [15:0] parityWord;
  logic [7:0]  parityView;
  assign parityWord = seedValid_reg ? parSeed_reg : (parityWordIn ^ parSeed_reg);
  always_comb
  begin
    if (!pwMode_reg)
      parityView = parityWordIn[7:0] ^ parityWordIn[15:8]; // R6
    else if (pHigh_reg)
      parityView = parityWord[15:8]; // R7
    else
      parityView = parityWord[7:0]; // R7
  end

  // Hardware set wins over software clear on both hold flags
  logic wideOddEnd;
  assign wideOddEnd = byteValid && lastBeat && oddEnd && wideXfer;

  always_ff @(posedge clk)
  begin
    if (rst)
      wSend_reg <= 1'b0;
    else if (wideOddEnd && xferSend && chain_reg)
      wSend_reg <= 1'b1; // R5
    else if (xferStart && (!xferSend || !wideXfer))
      wSend_reg <= 1'b0; // R10
    else if (byteValid && xferSend && wideXfer && wSend_reg)
      wSend_reg <= 1'b0; // R9
    else if (wr(swcc_pkg::IDX_WIDE_CHAIN) && wdat[swcc_pkg::BIT_WSEND])
      wSend_reg <= 1'b0; // R8
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      wRecv_reg <= 1'b0;
    else if (wideOddEnd && !xferSend)
      wRecv_reg <= 1'b1; // R14
    else if (xferStart && (xferSend || !wideXfer))
      wRecv_reg <= 1'b0; // R15
    else if (wr(swcc_pkg::IDX_CLK_DIV) && !wdat[swcc_pkg::BIT_WIDE_EN])
      wRecv_reg <= 1'b0; // R18
    else if (byteValid && !xferSend && wRecv_reg)
      wRecv_reg <= 1'b0; // R15
    else if (wr(swcc_pkg::IDX_WIDE_CHAIN) && wdat[swcc_pkg::BIT_WRECV])
      wRecv_reg <= 1'b0; // R13
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      residue_reg <= swcc_pkg::RESET_BYTE;
    else if (wideOddEnd && !xferSend)
      residue_reg <= byteIn[15:8]; // R14
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      odl_reg <= swcc_pkg::RESET_BYTE;
    else if (wideOddEnd && xferSend && chain_reg)
      odl_reg <= sendWordIn[7:0]; // R5
    else if (wr(swcc_pkg::IDX_ODL))
      odl_reg <= wdat;
  end
  // Send path: held byte goes out low, new byte high
  always_ff @(posedge clk)
  begin
    if (rst)
      busDataOut <= 16'h0000;
    else if (byteValid && xferSend)
    begin
      if (wSend_reg && wideXfer)
        busDataOut <= {sendWordIn[7:0], odl_reg}; // R9
      else if (wideXfer)
        busDataOut <= sendWordIn; // R17
      else
        busDataOut <= {8'h00, sendWordIn[7:0]}; // R17
    end
  end

  // Receive path to DMA
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      dmaDataOut <= 16'h0000;
      dmaValid   <= 1'b0;
    end
    else
    begin
      dmaValid <= byteValid && !xferSend;
      if (byteValid && !xferSend)
      begin
        if (wRecv_reg)
          dmaDataOut <= {byteIn[7:0], residue_reg}; // R15
        else if (wideOddEnd)
          dmaDataOut <= {8'h00, byteIn[7:0]}; // R14
        else if (wideXfer)
          dmaDataOut <= byteIn;
        else
          dmaDataOut <= {8'h00, byteIn[7:0]};
      end
    end
  end

  // Group code of first command byte
  logic isStd;
  assign isStd = swcc_pkg::STD_GROUPS[byteIn[7:5]];
  always_ff @(posedge clk)
  begin
    if (rst)
      firstByte_reg <= 1'b0;
    else if (xferStart)
      firstByte_reg <= 1'b1;
    else if (byteValid)
      firstByte_reg <= 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      gcKind_reg <= 1'b0;
    else if (firstByte_reg && byteValid && asyncTarget && !xferSend)
      gcKind_reg <= !isStd; // R11
  end
  always_ff @(posedge clk)
  begin
    if (rst)
      byteCountReload <= 1'b0;
    else
      byteCountReload <= firstByte_reg && byteValid && cmdPhase && !xferSend
                         && isStd && !rldDis_reg; // R12
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      clkDiv_reg <= 7'h00;
      ownId_reg  <= swcc_pkg::RESET_BYTE;
    end
    else
    begin
      if (wr(swcc_pkg::IDX_CLK_DIV))
        clkDiv_reg <= wdat[6:0] & swcc_pkg::MASK_CLK_DIV[6:0]; // R22
      if (wr(swcc_pkg::IDX_OWN_ID))
        ownId_reg <= wdat & swcc_pkg::MASK_OWN_ID; // R22
    end
  end

  // =====================================================
  // Clock enables: fractional divide by accumulating half steps
  logic [3:0] coreAcc_reg, syncAcc_reg;
  logic [2:0] coreStep, syncStep;
  assign coreStep = halfSteps(clkDiv_reg[2:0]); // R19
  assign syncStep = halfSteps(clkDiv_reg[6:4]); // R16
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      {coreClkEn, coreAcc_reg} <= 5'h00;
      {syncClkEn, syncAcc_reg} <= 5'h00;
    end
    else
    begin
      {coreClkEn, coreAcc_reg} <= accStep(coreAcc_reg, coreStep); // R19
      {syncClkEn, syncAcc_reg} <= accStep(syncAcc_reg, syncStep); // R16
    end
  end

  // =====================================================
  // Read mux and ack
  logic [7:0] rdByte;
  always_comb
  begin
    unique case (idx)
      swcc_pkg::IDX_WIDE_CHAIN: rdByte = {guard_reg, chain_reg, pwMode_reg, pHigh_reg,
                                          wSend_reg, gcKind_reg, rldDis_reg, wRecv_reg};
      swcc_pkg::IDX_CLK_DIV:    rdByte = {1'b0, clkDiv_reg};
      swcc_pkg::IDX_OWN_ID:     rdByte = ownId_reg;
      swcc_pkg::IDX_PARITY:     rdByte = parityView;
      swcc_pkg::IDX_RESIDUE:    rdByte = residue_reg;
      swcc_pkg::IDX_ODL:        rdByte = odl_reg;
      swcc_pkg::IDX_IRQ_STAT0:  rdByte = {5'h00, udc_reg, 2'h0};
      default:                  rdByte = 8'h00;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end
    else
    begin
      wb_ack_o <= hit && mapped;
      wb_err_o <= hit && !mapped;
      wb_dat_o <= (hit && mapped && !wb_we_i) ? {24'h000000, rdByte} : 32'h00000000;
    end
  end

  // =====================================================
  // Checks
  a_udc_raise: assert property (@(posedge clk) disable iff (rst) // R1
    initiatorMode && guard_reg && busFree |=> udc_reg)
    else $error("unexpected disconnect not flagged");
  a_guard_autoset: assert property (@(posedge clk) disable iff (rst) // R2
    scriptActive && reselected |=> guard_reg)
    else $error("guard not set on reselection");
  a_chain_follow: assert property (@(posedge clk) disable iff (rst) // R4
    chainedMoveOp |=> chain_reg)
    else $error("chained mode not set");
  a_wsend_recvclr: assert property (@(posedge clk) disable iff (rst) // R10
    xferStart && !xferSend && !wideOddEnd |=> !wSend_reg)
    else $error("send flag survived receive");
  a_wrecv_sendclr: assert property (@(posedge clk) disable iff (rst) // R15
    xferStart && xferSend && !wideOddEnd |=> !wRecv_reg)
    else $error("receive flag survived send");
  a_wrecv_set: assert property (@(posedge clk) disable iff (rst) // R14
    wideOddEnd && !xferSend |=> wRecv_reg && residue_reg == $past(byteIn[15:8]))
    else $error("partial receive not held");
  a_reload_disable: assert property (@(posedge clk) disable iff (rst) // R12
    rldDis_reg && $past(rldDis_reg) |-> !byteCountReload)
    else $error("reload despite disable");
  a_arb_id: assert property (@(posedge clk) disable iff (rst) // R21
    wr(swcc_pkg::IDX_OWN_ID) |=> arbId == $past(wdat[3:0]))
    else $error("own id not stored");
endmodule : swcc_wide_chain_clock_ctrl

// file: verif/swcc_scsi_side_model.sv
`timescale 1ns/1ps
module swcc_scsi_side_model (
  input  wire logic        clk,
  output logic             initiatorMode,
  output logic             busFree,
  output logic             scriptActive,
  output logic             reselected,
  output logic             selectDone,
  output logic             chainedMoveOp,
  output logic             blockMoveOp,
  output logic             xferStart,
  output logic             xferSend,
  output logic             dataPhase,
  output logic             cmdPhase,
  output logic             asyncTarget,
  output logic             byteValid,
  output logic [15:0]      byteIn,
  output logic             lastBeat,
  output logic             oddEnd,
  output logic [15:0]      sendWordIn,
  output logic [15:0]      parityWordIn
);
  initial
  begin
    {initiatorMode, busFree, scriptActive, reselected, selectDone} = 5'h00;
    {chainedMoveOp, blockMoveOp, xferStart, xferSend, dataPhase} = 5'h00;
    {cmdPhase, asyncTarget, byteValid, lastBeat, oddEnd} = 5'h00;
    byteIn = 16'h0000;
    sendWordIn = 16'h0000;
    parityWordIn = 16'h0000;
  end
  // =====================================================
  // Engine events: 0 reselect, 1 select, 2 chained move, 3 block move
  task automatic ev(input int k);
    @(posedge clk);
    case (k)
      0: reselected <= 1'b1;
      1: selectDone <= 1'b1;
      2: chainedMoveOp <= 1'b1;
      default: blockMoveOp <= 1'b1;
    endcase
    @(posedge clk);
    {reselected, selectDone, chainedMoveOp, blockMoveOp} <= 4'h0;
  endtask : ev
  // =====================================================
  // One-beat transfer; word lines flip after release, never hold stale data
  task automatic xfer(input logic send, input logic [15:0] w, input logic odd);
    @(posedge clk);
    xferSend <= send;
    xferStart <= 1'b1;
    sendWordIn <= w;
    @(posedge clk);
    xferStart <= 1'b0;
    byteValid <= 1'b1;
    byteIn <= w;
    lastBeat <= 1'b1;
    oddEnd <= odd;
    @(posedge clk);
    {byteValid, lastBeat, oddEnd} <= 3'h0;
    byteIn <= ~w;
    sendWordIn <= ~w;
  endtask : xfer
endmodule : swcc_scsi_side_model

// file: verif/tb_scsi_wide_chain_clock_ctrl.sv
`timescale 1ns/1ps
module tb_scsi_wide_chain_clock_ctrl;
  logic        clk, rst, we, cyc, stb, ack, err, reload, udc, dmaValid, wideXfer, coreEn, syncEn;
  logic [31:0] adr, datI, datO;
  logic [3:0]  sel, arbId;
  logic [15:0] busOut, dmaOut, byteIn, sendWordIn, parityWordIn;
  logic        initiatorMode, busFree, scriptActive, reselected, selectDone, chainedMoveOp;
  logic        blockMoveOp, xferStart, xferSend, dataPhase, cmdPhase, asyncTarget;
  logic        byteValid, lastBeat, oddEnd;
  int          failures, samples_checked;
  logic [7:0]  q;

  swcc_scsi_side_model m (.clk(clk), .initiatorMode(initiatorMode), .busFree(busFree),
    .scriptActive(scriptActive), .reselected(reselected), .selectDone(selectDone),
    .chainedMoveOp(chainedMoveOp), .blockMoveOp(blockMoveOp), .xferStart(xferStart),
    .xferSend(xferSend), .dataPhase(dataPhase), .cmdPhase(cmdPhase),
    .asyncTarget(asyncTarget), .byteValid(byteValid), .byteIn(byteIn), .lastBeat(lastBeat),
    .oddEnd(oddEnd), .sendWordIn(sendWordIn), .parityWordIn(parityWordIn));

  swcc_wide_chain_clock_ctrl dut (.clk(clk), .rst(rst), .wb_adr_i(adr), .wb_dat_i(datI),
    .wb_dat_o(datO), .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_ack_o(ack), .wb_err_o(err), .initiatorMode(initiatorMode), .busFree(busFree),
    .scriptActive(scriptActive), .reselected(reselected), .selectDone(selectDone),
    .chainedMoveOp(chainedMoveOp), .blockMoveOp(blockMoveOp), .xferStart(xferStart),
    .xferSend(xferSend), .dataPhase(dataPhase), .cmdPhase(cmdPhase),
    .asyncTarget(asyncTarget), .byteValid(byteValid), .byteIn(byteIn), .lastBeat(lastBeat),
    .oddEnd(oddEnd), .sendWordIn(sendWordIn), .parityWordIn(parityWordIn),
    .byteCountReload(reload), .unexpectedDisconnect(udc), .busDataOut(busOut),
    .dmaDataOut(dmaOut), .dmaValid(dmaValid), .wideXfer(wideXfer), .arbId(arbId),
    .coreClkEn(coreEn), .syncClkEn(syncEn));
  // =====================================================
  // Helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    samples_checked++;
    if (got !== exp)
    begin
      failures++;
      $display("wrong value at %0t: %s got %h expected %h", $time, msg, got, exp);
    end
  endtask : chk

  // Classic cycle; the request holds until the edge that samples ack or err
  task automatic wbx(input logic [7:0] a, input logic w, input logic [7:0] d,
                     output logic [7:0] r, output logic e);
    int n;
    @(posedge clk);
    adr <= {24'h000000, a};
    datI <= {24'h000000, d};
    we <= w;
    sel <= 4'hf;
    {cyc, stb} <= 2'h3;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && err !== 1'b1 && n < 50);
    r = datO[7:0];
    e = err;
    {cyc, stb, we} <= 3'h0;
    if (n >= 50) chk(16'h0001, 16'h0000, "bus answer missing");
  endtask : wbx

  task automatic rd(input logic [7:0] a, output logic [7:0] r);
    logic e;
    wbx(a, 1'b0, 8'h00, r, e);
  endtask : rd

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic e;
    wbx(a, 1'b1, d, r, e);
  endtask : wr
  // =====================================================
  // Scenarios
  task automatic t_regs;
    logic e;
    rd(8'h08, q);
    chk(16'(q), 16'h0000, "control reset value");
    wbx(8'h3c, 1'b0, 8'h00, q, e);
    chk(16'(e), 16'h0001, "unmapped address");
    wr(8'h10, 8'hff);
    rd(8'h10, q);
    chk(16'(q), 16'(swcc_pkg::MASK_OWN_ID), "own id reserved bits");
    chk(16'(arbId), 16'h000f, "arbitration id");
    wr(8'h0c, 8'hcc);
    rd(8'h0c, q);
    chk(16'(q), 16'(8'hcc & swcc_pkg::MASK_CLK_DIV), "divider reserved bit");
    $display("test registers done");
  endtask : t_regs

  task automatic t_guard;
    m.scriptActive <= 1'b1;
    m.ev(1);
    rd(8'h08, q);
    chk(16'(q[7]), 16'h0001, "guard after select");
    m.initiatorMode <= 1'b1;
    m.busFree <= 1'b1;
    repeat (3) @(posedge clk);
    chk(16'(udc), 16'h0001, "unexpected disconnect");
    m.busFree <= 1'b0;
    wr(8'h08, 8'h00);
    wr(8'h20, 8'h04);
    m.busFree <= 1'b1;
    repeat (3) @(posedge clk);
    chk(16'(udc), 16'h0000, "expected disconnect");
    m.busFree <= 1'b0;
    m.ev(0);
    rd(8'h08, q);
    chk(16'(q[7]), 16'h0001, "guard after reselect");
    wr(8'h08, 8'h00);
    $display("test guard done");
  endtask : t_guard

  task automatic t_chain_parity;
    m.ev(2);
    rd(8'h08, q);
    chk(16'(q[6]), 16'h0001, "chained set");
    m.ev(3);
    rd(8'h08, q);
    chk(16'(q[6]), 16'h0000, "chained cleared");
    m.parityWordIn <= 16'ha55a;
    wr(8'h08, 8'h20);
    rd(8'h14, q);
    chk(16'(q), 16'h005a, "parity low byte");
    wr(8'h08, 8'h30);
    rd(8'h14, q);
    chk(16'(q), 16'h00a5, "parity high byte");
    wr(8'h08, 8'h20);
    wr(8'h14, 8'h3c);
    rd(8'h14, q);
    chk(16'(q), 16'h003c, "parity seed");
    wr(8'h08, 8'h00);
    rd(8'h14, q);
    chk(16'(q), 16'h00ff, "parity legacy view");
    $display("test chain and parity done");
  endtask : t_chain_parity

  task automatic t_div;
    int expd [5] = '{20, 60, 40, 30, 20};
    int nc;
    int ns;
    for (int c = 0; c < 5; c++)
    begin
      wr(8'h0c, {1'b0, 3'(c), 1'b0, 3'(c)});
      repeat (4) @(posedge clk);
      nc = 0;
      ns = 0;
      repeat (60)
      begin
        @(posedge clk);
        nc += int'(coreEn === 1'b1);
        ns += int'(syncEn === 1'b1);
      end
      chk(16'(nc >= expd[c] - 1 && nc <= expd[c] + 1), 16'h0001, "core divider");
      chk(16'(ns >= expd[c] - 1 && ns <= expd[c] + 1), 16'h0001, "sync divider");
    end
    $display("test dividers done");
  endtask : t_div

  task automatic t_wide;
    wr(8'h0c, 8'h19);
    m.dataPhase <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk(16'(wideXfer), 16'h0001, "wide data phase");
    m.dataPhase <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk(16'(wideXfer), 16'h0000, "narrow outside data");
    m.dataPhase <= 1'b1;
    m.xfer(1'b0, 16'h3cc3, 1'b1);
    rd(8'h08, q);
    chk(16'(q[0]), 16'h0001, "receive hold set");
    chk(dmaOut, 16'h00c3, "low byte passed alone");
    rd(8'h18, q);
    chk(16'(q), 16'h003c, "held high byte");
    m.xfer(1'b0, 16'h7788, 1'b0);
    @(negedge clk);
    chk(dmaOut, 16'h883c, "held byte delivered");
    m.xfer(1'b0, 16'h2b1a, 1'b1);
    wr(8'h08, 8'h01);
    rd(8'h08, q);
    chk(16'(q[0]), 16'h0000, "receive hold cleared");
    m.xfer(1'b0, 16'h5aa5, 1'b1);
    wr(8'h0c, 8'h11);
    rd(8'h08, q);
    chk(16'(q[0]), 16'h0000, "wide off clears hold");
    wr(8'h0c, 8'h19);
    m.xfer(1'b0, 16'h0ff0, 1'b1);
    m.xfer(1'b1, 16'h1234, 1'b0);
    rd(8'h08, q);
    chk(busOut, 16'h1234, "wide send word");
    chk(16'(q[0]), 16'h0000, "send clears receive hold");
    m.ev(2);
    m.xfer(1'b1, 16'h7e81, 1'b1);
    rd(8'h08, q);
    chk(16'(q[3]), 16'h0001, "send hold set");
    rd(8'h1c, q);
    chk(16'(q), 16'h0081, "held send byte");
    wr(8'h08, 8'h08);
    rd(8'h08, q);
    chk(16'(q[3]), 16'h0000, "send hold cleared");
    m.ev(2);
    m.xfer(1'b1, 16'h6699, 1'b1);
    m.xfer(1'b1, 16'h1e2d, 1'b0);
    @(negedge clk);
    chk(busOut, 16'h2d99, "held byte sent low");
    m.xfer(1'b1, 16'h6699, 1'b1);
    m.xfer(1'b0, 16'h4411, 1'b0);
    rd(8'h08, q);
    chk(16'(q[3]), 16'h0000, "receive clears send hold");
    $display("test wide transfers done");
  endtask : t_wide

  task automatic t_group;
    m.cmdPhase <= 1'b1;
    m.asyncTarget <= 1'b1;
    m.xfer(1'b0, 16'h00c0, 1'b0);
    @(negedge clk);
    chk(16'(reload), 16'h0000, "no reload on vendor group");
    chk(16'(dmaValid), 16'h0001, "received byte to dma");
    rd(8'h08, q);
    chk(16'(q[2]), 16'h0001, "vendor group code");
    m.xfer(1'b0, 16'h0028, 1'b0);
    @(negedge clk);
    chk(16'(reload), 16'h0001, "reload on standard group");
    rd(8'h08, q);
    chk(16'(q[2]), 16'h0000, "standard group code");
    wr(8'h08, 8'h02);
    m.xfer(1'b0, 16'h0028, 1'b0);
    @(negedge clk);
    chk(16'(reload), 16'h0000, "reload disabled");
    wr(8'h08, 8'h00);
    m.cmdPhase <= 1'b0;
    m.asyncTarget <= 1'b0;
    $display("test group codes done");
  endtask : t_group

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // =====================================================
  // Clock, reset, sequence and watchdog
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    {rst, we, cyc, stb} = 4'h8;
    adr = 32'h00000000;
    datI = 32'h00000000;
    sel = 4'h0;
    failures = 0;
    samples_checked = 0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_guard();
    t_chain_parity();
    t_div();
    t_group();
    t_wide();
    give_verdict();
  end

  // Whole run needs about 530 cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    failures++;
    give_verdict();
  end
endmodule : tb_scsi_wide_chain_clock_ctrl
